// *** shared/lic_pkg.sv ***
// constants and types shared by the line interface control logic
`default_nettype none
package lic_pkg;
  // register offsets on the 4-bit host address
  localparam logic [3:0] OFS_GSTAT = 4'h0;
  localparam logic [3:0] OFS_GCTL = 4'h4;
  localparam logic [3:0] OFS_JCTL = 4'h5;
  localparam logic [3:0] OFS_CH0 = 4'h6;
  localparam logic [3:0] OFS_ST0 = 4'hA;
  // channel control fields
  localparam int BIT_STANDBY = 0;
  localparam int BIT_MASK = 1;
  localparam int BIT_LOOP_LO = 3;
  localparam int BIT_LOOP_HI = 4;
  // global control fields
  localparam int BIT_SOFT_RST = 1;
  localparam int BIT_TEST_SCOPE = 3;
  // attenuator control fields
  localparam int BIT_CDR = 0;
  localparam int BIT_JAR = 1;
  localparam int BIT_JAT = 2;
  // status fields
  localparam int BIT_ST_ANA = 0;
  localparam int BIT_ST_DIG = 1;
  localparam int BIT_ST_REF = 0;
  localparam int BIT_ST_TXC = 1;
  // values after reset
  localparam logic [7:0] GCTL_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // reference clock loss timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int REF_LOSS_MIN_NS = 150;
  localparam int REF_LOSS_MAX_NS = 700;
  localparam int REF_LOSS_CYC =
    (REF_LOSS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_LOSS_MAX_CYC = REF_LOSS_MAX_NS / CLK_PERIOD_NS;
  // loopback selection, {loop_select_hi, loop_select_lo}
  typedef enum logic [1:0] {
    LIC_NORMAL = 2'b00,
    LIC_FULL_LOCAL = 2'b01,
    LIC_REMOTE = 2'b10,
    LIC_DIGITAL_LOCAL = 2'b11
  } lic_loop_t;
endpackage
`default_nettype wire

// *** design/lic_top.sv ***
// control and test logic of a quad line interface
`default_nettype none
module lic_top #(
  parameter int NCH = 4,
  parameter int DIGITAL_SIGNAL_LOSS_ZEROS = 175
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hard_reset_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [NCH-1:0] sys_tx_data,
  input wire logic [NCH-1:0] sys_tx_valid,
  input wire logic [NCH-1:0] all_ones_request,
  input wire logic [NCH-1:0] line_rx_data,
  input wire logic [NCH-1:0] line_rx_valid,
  input wire logic [NCH-1:0] analog_signal_loss,
  output logic [NCH-1:0] sys_rx_data,
  output logic [NCH-1:0] sys_rx_valid,
  output logic [NCH-1:0] line_out_pos,
  output logic [NCH-1:0] line_out_neg,
  output logic [NCH-1:0] line_oe,
  output logic [NCH-1:0] digital_signal_loss,
  output logic [NCH-1:0] channel_standby,
  input wire logic reference_clock,
  output logic ref_clock_lost,
  output logic transmit_clock_lost,
  output logic rx_attenuator_on,
  output logic tx_attenuator_on,
  input wire logic in_circuit_test_n,
  output logic outputs_oe,
  input wire logic bus_multiplex_strap,
  input wire logic control_style_strap,
  input wire logic host_fast,
  output logic [1:0] host_bus_mode,
  output logic wait_state_output,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////
  // register decode helpers

  // true when the address hits a block of NCH registers from base
  function automatic logic in_block(input logic [3:0] a,
                                    input logic [3:0] base);
    logic [4:0] d;
    d = {1'b0, a} - {1'b0, base};
    in_block = (a >= base) && (d < 5'(NCH));
  endfunction

  // index within a block of NCH registers
  function automatic logic [1:0] blk_idx(input logic [3:0] a,
                                         input logic [3:0] base);
    logic [3:0] d;
    d = a - base;
    blk_idx = d[1:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // reset sources

  logic [7:0] gctl_ff;
  logic [7:0] jctl_ff;
  logic [7:0] chctl_ff [NCH];
  logic core_rst;
  logic scope_eff;

  // pin and soft bit share one internal reset
  // equal reset sources
  assign core_rst = rst | ~hard_reset_n | gctl_ff[lic_pkg::BIT_SOFT_RST];

  //////////////////////////////////////////////////////////////////////////
  // host registers

  // global register 4: hardware reset clears all but the soft reset bit
  // register 4 reset
  always_ff @(posedge clk) begin
    if (rst) begin
      gctl_ff <= lic_pkg::GCTL_RESET;
    end else if (ce) begin
      if (wr && addr == lic_pkg::OFS_GCTL) begin
        gctl_ff <= wdata;
      end else if (!hard_reset_n) begin
        gctl_ff <= {gctl_ff & (8'h01 << lic_pkg::BIT_SOFT_RST)};
      end
    end
  end

  // attenuator and channel control survive the internal reset
  // others unchanged
  always_ff @(posedge clk) begin
    if (rst) begin
      jctl_ff <= lic_pkg::REG_RESET;
      for (int c = 0; c < NCH; c++) begin
        chctl_ff[c] <= lic_pkg::REG_RESET;
      end
    end else if (ce && wr) begin
      if (addr == lic_pkg::OFS_JCTL) begin
        jctl_ff <= wdata;
      end
      if (in_block(addr, lic_pkg::OFS_CH0)) begin
        chctl_ff[blk_idx(addr, lic_pkg::OFS_CH0)] <= wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // host port mode and ready

  logic [1:0] mode_ff;
  logic ack_ff;

  // straps are caught while reset is held
  // bus style straps
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= {control_style_strap, bus_multiplex_strap};
    end
  end

  // ready follows each access for a fast host
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else if (ce) begin
      ack_ff <= wr | rd;
    end
  end

  assign host_bus_mode = mode_ff;
  // wait states only for fast hosts
  assign wait_state_output = host_fast ? ack_ff : 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // reference clock loss

  logic ref_q_ff;
  logic ref_qq_ff;
  logic [6:0] ref_cnt_ff;
  logic ref_lost_ff;
  logic ref_edge;

  assign ref_edge = ref_q_ff ^ ref_qq_ff;

  // count cycles without an edge, clear the flag on the next edge
  // loss window
  always_ff @(posedge clk) begin
    if (core_rst) begin
      ref_q_ff <= 1'b0;
      ref_qq_ff <= 1'b0;
      ref_cnt_ff <= 7'h00;
      ref_lost_ff <= 1'b0;
    end else if (ce) begin
      ref_q_ff <= reference_clock;
      ref_qq_ff <= ref_q_ff;
      if (ref_edge) begin
        ref_cnt_ff <= 7'h00;
        ref_lost_ff <= 1'b0;
      end else if (ref_cnt_ff < 7'(lic_pkg::REF_LOSS_CYC)) begin
        ref_cnt_ff <= ref_cnt_ff + 7'h01;
      end else begin
        ref_lost_ff <= 1'b1;
      end
    end
  end

  assign ref_clock_lost = ref_lost_ff;

  //////////////////////////////////////////////////////////////////////////
  // attenuator selection

  logic rx_att;
  logic tx_att;
  logic cdr_on;

  // both selects together leave the attenuator off
  // exclusive select
  assign rx_att = jctl_ff[lic_pkg::BIT_JAR] & ~jctl_ff[lic_pkg::BIT_JAT]
                & cdr_on;
  assign tx_att = jctl_ff[lic_pkg::BIT_JAT] & ~jctl_ff[lic_pkg::BIT_JAR]
                & ~ref_lost_ff;
  assign cdr_on = jctl_ff[lic_pkg::BIT_CDR] & ~ref_lost_ff;
  assign rx_attenuator_on = rx_att;
  assign tx_attenuator_on = tx_att;
  assign transmit_clock_lost = ref_lost_ff & jctl_ff[lic_pkg::BIT_JAT]
                             & ~jctl_ff[lic_pkg::BIT_JAR];

  //////////////////////////////////////////////////////////////////////////
  // channel data paths

  logic [NCH-1:0] fe_data;
  logic [NCH-1:0] fe_valid;
  logic [NCH-1:0] tx_bit;
  logic [NCH-1:0] tx_go;
  logic [NCH-1:0] rxo_data;
  logic [NCH-1:0] rxo_valid;
  logic [NCH-1:0] rx_blank;
  logic [NCH-1:0] standby;
  logic [NCH-1:0] pol_ff;
  logic [NCH-1:0] pos_ff;
  logic [NCH-1:0] neg_ff;
  logic [NCH-1:0] srx_d_ff;
  logic [NCH-1:0] srx_v_ff;
  logic [7:0] zcnt_ff [NCH];
  logic [NCH-1:0] dloss_ff;

  // path selection per channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      lic_pkg::lic_loop_t m;
      m = lic_pkg::lic_loop_t'({chctl_ff[c][lic_pkg::BIT_LOOP_HI],
                                chctl_ff[c][lic_pkg::BIT_LOOP_LO]});
      standby[c] = chctl_ff[c][lic_pkg::BIT_STANDBY];
      rx_blank[c] = 1'b0;
      case (m)
        lic_pkg::LIC_FULL_LOCAL: begin
          tx_go[c] = sys_tx_valid[c];
          tx_bit[c] = sys_tx_data[c] | all_ones_request[c];
          fe_data[c] = sys_tx_data[c];
          fe_valid[c] = sys_tx_valid[c];
          rxo_data[c] = fe_data[c];
          rxo_valid[c] = fe_valid[c];
        end
        lic_pkg::LIC_REMOTE: begin
          fe_data[c] = line_rx_data[c];
          fe_valid[c] = line_rx_valid[c];
          tx_go[c] = line_rx_valid[c];
          tx_bit[c] = line_rx_data[c];
          rxo_data[c] = fe_data[c];
          rxo_valid[c] = fe_valid[c];
        end
        lic_pkg::LIC_DIGITAL_LOCAL: begin
          fe_data[c] = line_rx_data[c];
          fe_valid[c] = line_rx_valid[c];
          tx_go[c] = sys_tx_valid[c];
          tx_bit[c] = sys_tx_data[c] | all_ones_request[c];
          rxo_data[c] = sys_tx_data[c];
          rxo_valid[c] = sys_tx_valid[c];
        end
        default: begin
          fe_data[c] = line_rx_data[c];
          fe_valid[c] = line_rx_valid[c];
          tx_go[c] = sys_tx_valid[c];
          tx_bit[c] = sys_tx_data[c] | all_ones_request[c];
          rxo_data[c] = fe_data[c];
          rxo_valid[c] = fe_valid[c];
        end
      endcase
      // receive blanked on reference loss with recovery or receive attenuator selected, except in digital local loop
      if (m != lic_pkg::LIC_DIGITAL_LOCAL
          && (jctl_ff[lic_pkg::BIT_CDR] || jctl_ff[lic_pkg::BIT_JAR])) begin
        rx_blank[c] = ref_lost_ff;
      end
    end
  end

  // line coding, receive retiming and zero run counting
  // path state reset
  always_ff @(posedge clk) begin
    if (core_rst) begin
      pol_ff <= '0;
      pos_ff <= '0;
      neg_ff <= '0;
      srx_d_ff <= '0;
      srx_v_ff <= '0;
      dloss_ff <= '0;
      for (int c = 0; c < NCH; c++) begin
        zcnt_ff[c] <= 8'h00;
      end
    end else if (ce) begin
      for (int c = 0; c < NCH; c++) begin
        if (standby[c]) begin
          pol_ff[c] <= 1'b0;
          pos_ff[c] <= 1'b0;
          neg_ff[c] <= 1'b0;
          srx_d_ff[c] <= 1'b0;
          srx_v_ff[c] <= 1'b0;
          dloss_ff[c] <= 1'b0;
          zcnt_ff[c] <= 8'h00;
        end else begin
          // alternate mark polarity on the line
          pos_ff[c] <= tx_go[c] & tx_bit[c] & ~pol_ff[c];
          neg_ff[c] <= tx_go[c] & tx_bit[c] & pol_ff[c];
          if (tx_go[c] && tx_bit[c]) begin
            pol_ff[c] <= ~pol_ff[c];
          end
          srx_d_ff[c] <= rxo_data[c] & ~rx_blank[c];
          srx_v_ff[c] <= rxo_valid[c] & ~rx_blank[c];
          if (fe_valid[c]) begin
            if (fe_data[c]) begin
              zcnt_ff[c] <= 8'h00;
              dloss_ff[c] <= 1'b0;
            end else if (zcnt_ff[c] < 8'(DIGITAL_SIGNAL_LOSS_ZEROS)) begin
              zcnt_ff[c] <= zcnt_ff[c] + 8'h01;
            end else begin
              dloss_ff[c] <= 1'b1;
            end
          end
        end
      end
    end
  end

  assign line_out_pos = pos_ff;
  assign line_out_neg = neg_ff;
  assign sys_rx_data = srx_d_ff;
  assign sys_rx_valid = srx_v_ff;
  assign digital_signal_loss = dloss_ff;
  assign channel_standby = standby;

  //////////////////////////////////////////////////////////////////////////
  // alarm status and interrupt

  logic [1:0] cond [NCH];
  logic [1:0] cond_q_ff [NCH];
  logic [1:0] stat_ff [NCH];
  logic [1:0] gcond;
  logic [1:0] gcond_q_ff;
  logic [1:0] gstat_ff;
  logic rd_g;
  logic rd_ch;
  logic [1:0] rd_i;
  logic ev;
  logic irq_ff;

  // analog loss on the real line
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      cond[c][lic_pkg::BIT_ST_ANA] = analog_signal_loss[c] & ~standby[c];
      cond[c][lic_pkg::BIT_ST_DIG] = dloss_ff[c];
    end
  end

  assign gcond = {transmit_clock_lost, ref_lost_ff};
  assign rd_g = rd && addr == lic_pkg::OFS_GSTAT;
  assign rd_ch = rd && in_block(addr, lic_pkg::OFS_ST0);
  assign rd_i = blk_idx(addr, lic_pkg::OFS_ST0);

  // new unmasked activations
  always_comb begin
    ev = |(gcond & ~gcond_q_ff);
    for (int c = 0; c < NCH; c++) begin
      if (!chctl_ff[c][lic_pkg::BIT_MASK]) begin
        ev = ev | (|(cond[c] & ~cond_q_ff[c]));
      end
    end
  end

  // sticky bits: activation wins, read clears only ended conditions
  // conditional clear
  always_ff @(posedge clk) begin
    if (core_rst) begin
      gcond_q_ff <= 2'b00;
      gstat_ff <= 2'b00;
      for (int c = 0; c < NCH; c++) begin
        cond_q_ff[c] <= 2'b00;
        stat_ff[c] <= 2'b00;
      end
    end else if (ce) begin
      gcond_q_ff <= gcond;
      gstat_ff <= (gcond & ~gcond_q_ff)
                | (gstat_ff & ~({2{rd_g}} & ~gcond));
      for (int c = 0; c < NCH; c++) begin
        cond_q_ff[c] <= cond[c];
        stat_ff[c] <= (cond[c] & ~cond_q_ff[c])
                    | (stat_ff[c] & ~({2{rd_ch && rd_i == 2'(c)}}
                                      & ~cond[c]));
      end
    end
  end

  // interrupt set per activation, dropped by a status read
  // interrupt per activation
  always_ff @(posedge clk) begin
    if (core_rst) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      if (ev) begin
        irq_ff <= 1'b1;
      end else if (rd_g || rd_ch) begin
        irq_ff <= 1'b0;
      end
    end
  end

  assign irq = irq_ff;

  //////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] rdata_ff;

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (ce) begin
      rdata_ff <= 8'h00;
      if (rd) begin
        if (addr == lic_pkg::OFS_GSTAT) begin
          rdata_ff <= {6'h00, gstat_ff};
        end else if (addr == lic_pkg::OFS_GCTL) begin
          rdata_ff <= gctl_ff;
        end else if (addr == lic_pkg::OFS_JCTL) begin
          rdata_ff <= jctl_ff;
        end else if (in_block(addr, lic_pkg::OFS_CH0)) begin
          rdata_ff <= chctl_ff[blk_idx(addr, lic_pkg::OFS_CH0)];
        end else if (rd_ch) begin
          rdata_ff <= {6'h00, stat_ff[rd_i]};
        end
      end
    end
  end

  assign rdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////////
  // in-circuit test output enables

  // hardware reset forces the all-outputs scope
  // tristate scope
  assign scope_eff = hard_reset_n & gctl_ff[lic_pkg::BIT_TEST_SCOPE];
  assign outputs_oe = in_circuit_test_n | scope_eff;
  assign line_oe = {NCH{in_circuit_test_n}} & ~standby;

endmodule
`default_nettype wire

// *** design/lic_fix_note.sv ***
// intentionally empty design unit
`default_nettype none
`default_nettype wire

// *** testbench/lic_asserts.sv ***
// port checker for the line interface control block
`default_nettype none
module lic_asserts #(
  parameter int NCH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hard_reset_n,
  input wire logic wr,
  input wire logic rd,
  input wire logic [NCH-1:0] line_oe,
  input wire logic [NCH-1:0] channel_standby,
  input wire logic reference_clock,
  input wire logic ref_clock_lost,
  input wire logic transmit_clock_lost,
  input wire logic rx_attenuator_on,
  input wire logic tx_attenuator_on,
  input wire logic in_circuit_test_n,
  input wire logic outputs_oe,
  input wire logic host_fast,
  input wire logic wait_state_output,
  input wire logic irq
);
  localparam int EARLY = 18;
  localparam int LATE = 87;
  logic [7:0] still_ff;
  logic ref_d_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // cycles since the reference clock last changed
  always_ff @(posedge clk) begin
    ref_d_ff <= reference_clock;
    if (rst || !hard_reset_n || reference_clock != ref_d_ff) begin
      still_ff <= 8'h00;
    end else if (still_ff != 8'hff) begin
      still_ff <= still_ff + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_standby_quiet: assert property ((channel_standby & line_oe) == '0)
    else $error("standby channel drives line");
  a_test_lines: assert property (!in_circuit_test_n |-> line_oe == '0)
    else $error("line driven with test pin low");
  a_test_keep: assert property (in_circuit_test_n |-> outputs_oe)
    else $error("outputs off without test pin");
  a_test_reset: assert property (
    !in_circuit_test_n && !hard_reset_n && $past(!hard_reset_n)
    |-> !outputs_oe)
    else $error("hard reset does not float all outputs");
  a_att_excl: assert property (
    !(rx_attenuator_on && tx_attenuator_on))
    else $error("attenuator on in both paths");
  a_tx_lost: assert property (transmit_clock_lost |-> ref_clock_lost)
    else $error("tx clock loss without reference loss");
  a_ref_early: assert property (
    $rose(ref_clock_lost) |-> still_ff >= EARLY)
    else $error("reference loss flagged too early");
  a_ref_late: assert property (still_ff >= LATE |-> ref_clock_lost)
    else $error("reference loss flagged too late");
  a_ref_clear: assert property (ref_clock_lost &&
    reference_clock != ref_d_ff |-> ##[1:4] !ref_clock_lost)
    else $error("reference loss not cleared by edge");
  a_slow_ready: assert property (!host_fast && $past(!host_fast)
    |-> wait_state_output)
    else $error("slow host made to wait");
  a_fast_ack: assert property (
    host_fast && (wr || rd) |=> wait_state_output)
    else $error("fast host access not acknowledged");
  a_irq_reset: assert property (!hard_reset_n |=> !irq)
    else $error("interrupt active in reset");
  c_ref_lost: cover property ($rose(ref_clock_lost));
  c_irq_drop: cover property ($fell(irq));
  c_test_lines: cover property (!in_circuit_test_n && outputs_oe);
  c_fast_wr: cover property (host_fast && wr);
endmodule
bind lic_top lic_asserts #(.NCH(NCH)) chk_u (.clk(clk), .rst(rst),
  .hard_reset_n(hard_reset_n), .wr(wr), .rd(rd), .line_oe(line_oe),
  .channel_standby(channel_standby), .reference_clock(reference_clock),
  .ref_clock_lost(ref_clock_lost),
  .transmit_clock_lost(transmit_clock_lost),
  .rx_attenuator_on(rx_attenuator_on), .tx_attenuator_on(tx_attenuator_on),
  .in_circuit_test_n(in_circuit_test_n), .outputs_oe(outputs_oe),
  .host_fast(host_fast), .wait_state_output(wait_state_output), .irq(irq));
`default_nettype wire

// *** testbench/lic_host_model.sv ***
// host processor model driving the register port
`default_nettype none
module lic_host_model (
  input wire logic clk,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one write cycle, data scrambled once released
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // one read cycle, data taken by the watcher
  task automatic get(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the line interface control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 4;
  logic clk, rst, ce, hard_reset_n, wr, rd, reference_clock, run_ref;
  logic in_circuit_test_n, bus_multiplex_strap, control_style_strap;
  logic host_fast, ref_clock_lost, transmit_clock_lost, outputs_oe;
  logic rx_attenuator_on, tx_attenuator_on, wait_state_output, irq, rd_d;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, e;
  logic [1:0] host_bus_mode;
  logic [NCH-1:0] sys_tx_data, sys_tx_valid, all_ones_request, line_rx_data;
  logic [NCH-1:0] line_rx_valid, analog_signal_loss, sys_rx_data;
  logic [NCH-1:0] sys_rx_valid, line_out_pos, line_out_neg, line_oe;
  logic [NCH-1:0] digital_signal_loss, channel_standby, sb;
  logic [7:0] ctl [NCH];
  logic [7:0] exp_q [$];
  int mismatches, num_checks;
  integer seed;
  ////////////////////////////////////////////////////////////////////////
  lic_host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));
  lic_top #(.NCH(NCH), .DIGITAL_SIGNAL_LOSS_ZEROS(4)) dut_u (.clk(clk), .rst(rst),
    .ce(ce), .hard_reset_n(hard_reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sys_tx_data(sys_tx_data),
    .sys_tx_valid(sys_tx_valid), .all_ones_request(all_ones_request),
    .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
    .analog_signal_loss(analog_signal_loss), .sys_rx_data(sys_rx_data),
    .sys_rx_valid(sys_rx_valid), .line_out_pos(line_out_pos),
    .line_out_neg(line_out_neg), .line_oe(line_oe),
    .digital_signal_loss(digital_signal_loss),
    .channel_standby(channel_standby), .reference_clock(reference_clock),
    .ref_clock_lost(ref_clock_lost),
    .transmit_clock_lost(transmit_clock_lost),
    .rx_attenuator_on(rx_attenuator_on), .tx_attenuator_on(tx_attenuator_on),
    .in_circuit_test_n(in_circuit_test_n), .outputs_oe(outputs_oe),
    .bus_multiplex_strap(bus_multiplex_strap),
    .control_style_strap(control_style_strap), .host_fast(host_fast),
    .host_bus_mode(host_bus_mode), .wait_state_output(wait_state_output),
    .irq(irq));
  ////////////////////////////////////////////////////////////////////////
  // free running system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // reference clock toggles only while enabled
  always @(posedge clk) begin
    if (run_ref) reference_clock <= ~reference_clock;
  end
  // watcher compares read data with the oldest note
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) check(rdata, exp_q.pop_front());
  end
  // watchdog cuts a hang short
  initial begin
    #(8 * 20000);
    mismatches++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic rd_exp(input logic [3:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    host_u.get(a);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 11924;
    mismatches = 0;
    num_checks = 0;
    {rst, ce, hard_reset_n, run_ref, in_circuit_test_n} = 5'h1f;
    {reference_clock, bus_multiplex_strap, control_style_strap} = 3'h2;
    host_fast = 1'b0;
    {sys_tx_data, all_ones_request, analog_signal_loss} = '0;
    {sys_tx_valid, line_rx_data, line_rx_valid} = '1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    check({6'h00, host_bus_mode}, 8'h01);
    check({7'h00, wait_state_output}, 8'h01);
    host_u.put(lic_pkg::OFS_GCTL, 8'h00);
    for (int i = 0; i < NCH; i++) begin
      ctl[i] = 8'($random(seed)) & 8'h19;
      if (ctl[i][0]) ctl[i][1] = 1'b1;
      sb[i] = ctl[i][0];
      host_u.put(lic_pkg::OFS_CH0 + 4'(i), ctl[i]);
    end
    for (int i = 0; i < NCH; i++) begin
      rd_exp(lic_pkg::OFS_CH0 + 4'(i), ctl[i]);
    end
    cyc(1);
    check({4'h0, channel_standby}, {4'h0, sb});
    // every loop mode on channel 0, all-ones requested meanwhile
    for (int m = 0; m < 4; m++) begin
      // standby left before data arrives, settle time shortened
      host_u.put(lic_pkg::OFS_CH0, 8'(m << 3));
      @(posedge clk);
      e = 8'($random(seed));
      sys_tx_data <= {3'h0, e[0]};
      line_rx_data <= {3'h7, ~e[0]};
      all_ones_request <= 4'h1;
      cyc(4);
      e[2:1] = {1'b1, e[0] ^ (m == 0 || m == 2)};
      e[3] = (m == 2) ? ~e[0] : 1'b1;
      check({6'h00, sys_rx_valid[0], sys_rx_data[0]}, {6'h00, e[2:1]});
      check({7'h00, line_out_pos[0] | line_out_neg[0]}, {7'h00, e[3]});
    end
    // full local loop: digital loss follows the looped data only
    host_u.put(lic_pkg::OFS_CH0, 8'h08);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      sys_tx_data <= {NCH{k == 0}};
      line_rx_data <= {NCH{k != 0}};
      all_ones_request <= '0;
      cyc(8);
      check({7'h00, digital_signal_loss[0]}, 8'(k));
    end
    @(posedge clk);
    {sys_tx_data, line_rx_data} <= '1;
    all_ones_request <= '0;
    host_u.put(lic_pkg::OFS_CH0, 8'h00);
    for (int i = 1; i < NCH; i++) host_u.put(lic_pkg::OFS_CH0 + 4'(i), 8'h03);
    cyc(1);
    check({4'h0, line_oe}, 8'h01);
    check({7'h00, digital_signal_loss[0]}, 8'h00);
    // pending alarm then soft reset held long enough
    @(posedge clk);
    analog_signal_loss <= 4'h1;
    @(posedge clk);
    analog_signal_loss <= 4'h0;
    cyc(3);
    check({7'h00, irq}, 8'h01);
    host_u.put(lic_pkg::OFS_GCTL, 8'h02);
    cyc(1250);
    host_u.put(lic_pkg::OFS_GCTL, 8'h00);
    cyc(2);
    check({7'h00, irq}, 8'h00);
    rd_exp(lic_pkg::OFS_ST0, 8'h00);
    rd_exp(lic_pkg::OFS_CH0 + 4'h1, 8'h03);
    // status stays while condition lasts
    @(posedge clk);
    analog_signal_loss <= 4'h1;
    cyc(3);
    check({7'h00, irq}, 8'h01);
    rd_exp(lic_pkg::OFS_ST0, 8'h01);
    cyc(2);
    check({7'h00, irq}, 8'h00);
    rd_exp(lic_pkg::OFS_ST0, 8'h01);
    @(posedge clk);
    analog_signal_loss <= 4'h0;
    cyc(2);
    rd_exp(lic_pkg::OFS_ST0, 8'h01);
    rd_exp(lic_pkg::OFS_ST0, 8'h00);
    // test pin with narrow scope, then hard reset widens it
    host_u.put(lic_pkg::OFS_GCTL, 8'h08);
    @(posedge clk);
    in_circuit_test_n <= 1'b0;
    cyc(1);
    check({7'h00, outputs_oe}, 8'h01);
    check({4'h0, line_oe}, 8'h00);
    @(posedge clk);
    hard_reset_n <= 1'b0;
    cyc(1250);
    check({7'h00, outputs_oe}, 8'h00);
    @(posedge clk);
    {hard_reset_n, in_circuit_test_n} <= 2'h3;
    cyc(1);
    rd_exp(lic_pkg::OFS_GCTL, 8'h00);
    rd_exp(lic_pkg::OFS_CH0 + 4'h2, 8'h03);
    host_u.put(lic_pkg::OFS_GCTL, 8'h00);
    // every attenuator selection
    for (int v = 0; v < 8; v++) begin
      host_u.put(lic_pkg::OFS_JCTL, 8'(v));
      cyc(1);
      e = {6'h00, v[0] & v[1] & !v[2], v[2] & !v[1]};
      check({6'h00, rx_attenuator_on, tx_attenuator_on}, e);
    end
    // reference clock stops with transmit attenuator only
    host_u.put(lic_pkg::OFS_JCTL, 8'h04);
    @(posedge clk);
    run_ref <= 1'b0;
    cyc(lic_pkg::REF_LOSS_MAX_CYC + 2);
    check({7'h00, ref_clock_lost}, 8'h01);
    check({7'h00, transmit_clock_lost}, 8'h01);
    check({7'h00, sys_rx_valid[0]}, 8'h01);
    check({7'h00, irq}, 8'h01);
    @(posedge clk);
    run_ref <= 1'b1;
    cyc(5);
    check({7'h00, ref_clock_lost}, 8'h00);
    rd_exp(lic_pkg::OFS_GSTAT, 8'h03);
    rd_exp(lic_pkg::OFS_GSTAT, 8'h00);
    // writes are ignored while the clock enable is low
    @(posedge clk);
    ce <= 1'b0;
    host_u.put(lic_pkg::OFS_JCTL, 8'h07);
    ce <= 1'b1;
    rd_exp(lic_pkg::OFS_JCTL, 8'h04);
    // fast host, a write then a read one idle cycle later
    @(posedge clk);
    host_fast <= 1'b1;
    host_u.put(lic_pkg::OFS_JCTL, 8'h01);
    rd_exp(lic_pkg::OFS_JCTL, 8'h01);
    cyc(3);
    end_sim();
  end
endmodule
`default_nettype wire
